/* File: cpu_core_model.sv */
// Model of the CPU core that ends instructions and stacks the condition codes.
// Assumes the resolver answers take_irq one edge after instr_done.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic fetching,
   input wire logic take_irq,
   output logic instr_done,
   output logic stacked
);
   // ==========================================================
   // Instruction boundaries every fourth cycle once the restart fetch is over.
   logic [1:0] cnt_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 2'h0;
         instr_done <= 1'b0;
         stacked <= 1'b0;
      end else begin
         cnt_q <= (run && !fetching) ? cnt_q + 2'h1 : 2'h0;
         instr_done <= run && !fetching && cnt_q == 2'h3;
         stacked <= take_irq;
      end
   end
endmodule : cpu_core_model
`default_nettype wire

/* File: reset_interrupt_priority_resolver.sv */
// Reset and interrupt priority resolver with its configuration register.
// Assumes the CPU core pulses instr_done at each instruction boundary and
// that the mode pins and external request pin are asynchronous.
//
// Summary of operation
// - Non-maskable order: reset, clock monitor, watchdog, nmi pin, illegal op, trap.
// - Default maskable order: irq, rti, ic1-3, oc1-4, ic4/oc5, tov, paov, pae, spi, sci.
// - The selected maskable source is raised above the others; the rest keep order.
// - A promoted source is still gated by the global mask and its local enable.
// - Vectors stay fixed per source regardless of promotion.
// - Priority register writes are accepted only while the global mask is set.
// - Reset loads priority select with 0110, favouring the external pin.
// - The external interrupt pin is level sensitive after reset.
// - Mode pins are captured at reset release into boot, special and mode-a bits.
// - Upper register bits reset per mode; visibility set only in special test.
// - In special modes, writing special and mode-a bits changes operating mode.
// - After reset three vector fetch cycles precede instruction execution.
// - Reset sets nmi mask, global mask and stop disable.
// - Reset clears clock monitor enable.
// - Watchdog enabled unless disable bit set; shortest rate after reset.
// - Reset clears realtime flag, its rate bits, and masks that source.
// - Reset clears timer flags and all nine timer interrupt enables.
// - Reset masks all serial interface interrupts in every mode.
// - Priority codes decode to one source; reserved 0101 acts as 0110.
// - The winner's vector is supplied: reset FFFE, clock FFFC, watchdog FFFA.
// - After stacking, set global mask, and nmi mask when nmi is pending.
`timescale 1ns/1ps
`default_nettype none
module reset_interrupt_priority_resolver #(
   parameter int NUM_SRC = resolver_pkg::NUM_MASKABLE
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic watchdog_disable,
   input wire logic por_req,
   input wire logic clkmon_req,
   input wire logic watchdog_req,
   input wire logic nonmaskable_pin_n,
   input wire logic irq_pin_n,
   input wire logic illegal_op,
   input wire logic software_trap,
   input wire logic [NUM_SRC-1:0] periph_req,
   input wire logic instr_done,
   input wire logic stacked,
   input wire logic global_mask_clear,
   input wire logic nonmaskable_mask_clear,
   output logic fetching,
   output logic take_irq,
   output logic [15:0] vector,
   output logic global_mask,
   output logic nonmaskable_mask,
   output logic stop_disable,
   output logic clock_monitor_enable,
   output logic watchdog_enable,
   output logic [1:0] watchdog_rate,
   output logic [1:0] realtime_rate,
   output logic [2:0] mode
);
   // ==========================================================
   // Input synchronisers
   // Request pins reset to their idle high level, so no false request follows reset.
   // Only the second stage of each synchroniser is read by the logic below.
   logic [1:0] ma_s, mb_s, nmi_s, irq_s;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ma_s <= 2'h0;
         mb_s <= 2'h0;
         nmi_s <= 2'h3;
         irq_s <= 2'h3;
      end else begin
         ma_s <= {ma_s[0], mode_pin_a};
         mb_s <= {mb_s[0], mode_pin_b};
         nmi_s <= {nmi_s[0], nonmaskable_pin_n};
         irq_s <= {irq_s[0], irq_pin_n};
      end
   end
   // Level sensitive, so wired-OR requesters hold it until serviced.
   logic irq_level;
   assign irq_level = ~irq_s[1];
   // The pin request is a level; only the pin mask gates it, and reset, clock monitor and watchdog rank above it.
   logic nmi_pend;
   assign nmi_pend = ~nmi_s[1];

   // ==========================================================
   // Mode capture and startup sequence
   // Capture happens on the third edge after release once pins are synchronised.
   logic [1:0] cap_cnt_q;
   logic captured_q;
   logic [1:0] fetch_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cap_cnt_q <= 2'h0;
      end else if (cap_cnt_q != 2'h2) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
      end
   end
   // The counter stops at two and the captured flag makes the capture a single event.
   logic cap_now;
   assign cap_now = (cap_cnt_q == 2'h2) && !captured_q;

   logic boot_rom_read_q, special_mode_bit_q, mode_a_bit_q, irv_q;
   logic [3:0] psel_q;
   logic hp_wr;
   assign hp_wr = wr && (addr == resolver_pkg::PRIORITY_MISC_ADDR);
   // Priority writes are dropped while maskable interrupts are enabled.
   // This avoids a race between a new selection and an arbitration in progress.
   logic hp_ok;
   assign hp_ok = hp_wr && global_mask;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         captured_q <= 1'b0;
         boot_rom_read_q <= 1'b0;
         special_mode_bit_q <= 1'b0;
         mode_a_bit_q <= 1'b0;
         irv_q <= 1'b0;
      end else if (cap_now) begin
         captured_q <= 1'b1;
         boot_rom_read_q <= ~mb_s[1] & ~ma_s[1];
         special_mode_bit_q <= ~mb_s[1];
         mode_a_bit_q <= ma_s[1];
         irv_q <= ~mb_s[1] & ma_s[1];
      end else if (hp_ok) begin
         // Boot, special and mode-a bits are writable only in the special modes.
         if (special_mode_bit_q) begin
            // Boot read has meaning only in special modes, so it clears with that bit.
            boot_rom_read_q <= wdata[resolver_pkg::BOOT_BIT] & wdata[resolver_pkg::SPECIAL_BIT];
            special_mode_bit_q <= wdata[resolver_pkg::SPECIAL_BIT];
            mode_a_bit_q <= wdata[resolver_pkg::MODE_A_BIT];
         end
         irv_q <= wdata[resolver_pkg::IRV_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         psel_q <= resolver_pkg::PSEL_RESET;
      end else if (hp_ok) begin
         // All four bits load together, so arbitration never sees a half-written code.
         psel_q <= wdata[3:0];
      end
   end

   // The special and mode-a bits together select one of four operating modes.
   always_comb begin
      unique case ({special_mode_bit_q, mode_a_bit_q})
         2'h0: mode = resolver_pkg::MODE_SINGLE;
         2'h1: mode = resolver_pkg::MODE_EXPANDED;
         2'h2: mode = resolver_pkg::MODE_BOOT;
         2'h3: mode = resolver_pkg::MODE_TEST;
      endcase
   end

   // Restart vector fetch occupies three cycles after capture.
   // Counting stops at the done code, so fetching falls once and then stays low.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fetch_q <= 2'h0;
      end else if (cap_now || (fetch_q != 2'h0 && fetch_q != resolver_pkg::FETCH_DONE)) begin
         fetch_q <= fetch_q + 2'h1;
      end
   end
   assign fetching = !captured_q || (fetch_q != resolver_pkg::FETCH_DONE);

   // ==========================================================
   // Condition code masks and control register
   // Control register: stop disable, clock monitor enable, watchdog and realtime rates.
   logic ctrl_wr;
   assign ctrl_wr = wr && (addr == resolver_pkg::CTRL_ADDR);
   // Two enable registers at consecutive addresses cover the fourteen peripheral sources.
   logic [NUM_SRC-1:0] local_en_q;
   logic en_wr;
   assign en_wr = wr && ((addr == resolver_pkg::ENABLE_LO_ADDR) ||
      (addr == resolver_pkg::ENABLE_HI_ADDR));

   // A stacking event wins over a clear from the CPU in the same cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         global_mask <= 1'b1;
         nonmaskable_mask <= 1'b1;
      end else if (stacked) begin
         global_mask <= 1'b1;
         // The pin mask is set only if the pin still requests at stacking time.
         if (nmi_pend) begin
            nonmaskable_mask <= 1'b1;
         end
      end else begin
         if (global_mask_clear) begin
            global_mask <= 1'b0;
         end
         if (nonmaskable_mask_clear) begin
            nonmaskable_mask <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stop_disable <= 1'b1;
         clock_monitor_enable <= 1'b0;
         watchdog_rate <= 2'h0;
         realtime_rate <= 2'h0;
      end else if (ctrl_wr) begin
         stop_disable <= wdata[7];
         clock_monitor_enable <= wdata[6];
         watchdog_rate <= wdata[3:2];
         realtime_rate <= wdata[1:0];
      end
   end

   // Watchdog enable follows the disable strap, caught after release.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         watchdog_enable <= 1'b0;
      end else if (cap_now) begin
         watchdog_enable <= ~watchdog_disable;
      end
   end

   // Local enables: bit 0 realtime, bits 1..9 timer, 10..12 accumulators/spi, 13 sci.
   // The top enable bit has no source behind it and only reads back.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         local_en_q <= '0;
      end else if (en_wr) begin
         if (addr == resolver_pkg::ENABLE_HI_ADDR) begin
            local_en_q[NUM_SRC-1:8] <= wdata[NUM_SRC-9:0];
         end else begin
            local_en_q[7:0] <= wdata;
         end
      end
   end

   // ==========================================================
   // Maskable arbitration
   // Index 0 is the external pin, then realtime, timer, accumulator, spi, sci.
   // The external pin has no local enable; each peripheral source has one.
   // All requests drop out while the global mask is set.
   logic [NUM_SRC-1:0] req_m;
   always_comb begin
      req_m = '0;
      req_m[0] = irq_level;
      req_m[NUM_SRC-1:1] = periph_req[NUM_SRC-1:1] & local_en_q[NUM_SRC-2:0];
      if (global_mask) begin
         req_m = '0;
      end
   end

   // Map priority code to default-order index.
   // The reserved code promotes the external pin, exactly as its own code does.
   function automatic int psel_index(input logic [3:0] p);
      int r;
      r = 0;
      unique case (p)
         4'h0: r = 10;
         4'h1: r = 11;
         4'h2: r = 12;
         4'h3: r = 13;
         4'h4: r = 14;
         4'h5, 4'h6: r = 0;
         4'h7: r = 1;
         4'h8: r = 2;
         4'h9: r = 3;
         4'hA: r = 4;
         4'hB: r = 5;
         4'hC: r = 6;
         4'hD: r = 7;
         4'hE: r = 8;
         4'hF: r = 9;
      endcase
      return r;
   endfunction

   // Vectors descend by two from the external pin's vector and never follow promotion.
   function automatic logic [15:0] mvec(input int i);
      return 16'hFFF2 - 16'(2 * i);
   endfunction

   logic [15:0] mask_vec;
   logic mask_hit;
   int prom;
   always_comb begin
      prom = psel_index(psel_q);
      mask_hit = 1'b0;
      mask_vec = resolver_pkg::VEC_NONE;
      // The scan runs from lowest to highest rank, so the last hit is the default winner.
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req_m[i]) begin
            mask_hit = 1'b1;
            mask_vec = mvec(i);
         end
      end
      // A promoted source that is requesting overrides the default winner.
      if (req_m[prom]) begin
         mask_vec = mvec(prom);
      end
   end

   // ==========================================================
   // Non-maskable arbitration and winner output
   // Clock monitor and watchdog requests count only while their enables are set.
   // Software trap has the lowest rank of the non-maskable sources.
   logic [15:0] win_vec;
   logic win_hit;
   always_comb begin
      win_hit = 1'b1;
      if (por_req) begin
         win_vec = resolver_pkg::VEC_RESET;
      end else if (clkmon_req && clock_monitor_enable) begin
         win_vec = resolver_pkg::VEC_CLKMON;
      end else if (watchdog_req && watchdog_enable) begin
         win_vec = resolver_pkg::VEC_WDOG;
      end else if (nmi_pend && !nonmaskable_mask) begin
         win_vec = resolver_pkg::VEC_NMI;
      end else if (illegal_op) begin
         win_vec = resolver_pkg::VEC_ILLOP;
      end else if (software_trap) begin
         win_vec = resolver_pkg::VEC_SWTRAP;
      end else begin
         win_vec = mask_vec;
         win_hit = mask_hit;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         take_irq <= 1'b0;
         vector <= resolver_pkg::VEC_RESET;
      end else if (instr_done && !fetching) begin
         take_irq <= win_hit;
         // The vector stands until the next take, so a boundary with no winner keeps it.
         if (win_hit) begin
            vector <= win_vec;
         end
      end else begin
         take_irq <= 1'b0;
      end
   end

   // ==========================================================
   // Register read port
   // Read data stand for one cycle after the strobe and read as zero otherwise.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            resolver_pkg::PRIORITY_MISC_ADDR:
               rdata <= {boot_rom_read_q, special_mode_bit_q, mode_a_bit_q, irv_q, psel_q};
            resolver_pkg::CTRL_ADDR:
               rdata <= {stop_disable, clock_monitor_enable, 2'h0, watchdog_rate, realtime_rate};
            // Status is read only: masks, watchdog enable, fetch state and mode.
            resolver_pkg::STATUS_ADDR:
               rdata <= {global_mask, nonmaskable_mask, watchdog_enable, fetching, 1'b0, mode};
            resolver_pkg::ENABLE_LO_ADDR: rdata <= local_en_q[7:0];
            resolver_pkg::ENABLE_HI_ADDR: rdata <= {1'b0, local_en_q[NUM_SRC-1:8]};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule : reset_interrupt_priority_resolver
`default_nettype wire

/* File: reset_interrupt_priority_resolver_test.sv */
// Self-checking bench for the reset and interrupt priority resolver.
// Assumes the package, the CPU model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module reset_interrupt_priority_resolver_test;
   // ==========================================================
   // Wiring
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic mode_pin_a = 1'b0, mode_pin_b = 1'b0, watchdog_disable = 1'b0;
   logic por_req = 1'b0, clkmon_req = 1'b0, watchdog_req = 1'b0;
   logic illegal_op = 1'b0, software_trap = 1'b0;
   logic global_mask_clear = 1'b0, nonmaskable_mask_clear = 1'b0;
   logic nonmaskable_pin_n = 1'b1, irq_pin_n = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [14:0] periph_req = 15'h0000;
   logic instr_done, stacked, fetching, take_irq, global_mask, nonmaskable_mask;
   logic stop_disable, clock_monitor_enable, watchdog_enable;
   logic [7:0] rdata;
   logic [15:0] vector;
   logic [1:0] watchdog_rate, realtime_rate;
   logic [2:0] mode;
   int n_mismatch = 0, check_count = 0, cycles = 0;
   always #2.5 clk = ~clk;
   reset_interrupt_priority_resolver dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .mode_pin_a, .mode_pin_b, .watchdog_disable, .por_req, .clkmon_req, .watchdog_req,
      .nonmaskable_pin_n, .irq_pin_n, .illegal_op, .software_trap, .periph_req, .instr_done,
      .stacked, .global_mask_clear, .nonmaskable_mask_clear, .fetching, .take_irq, .vector,
      .global_mask, .nonmaskable_mask, .stop_disable, .clock_monitor_enable, .watchdog_enable,
      .watchdog_rate, .realtime_rate, .mode);
   cpu_core_model cpu (.clk, .rstn, .run, .fetching, .take_irq, .instr_done, .stacked);
   // ==========================================================
   // Shared tasks
   task automatic stop_test;
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, exp});
   endtask : rreg
   task automatic clr(input logic i, input logic x);
      @(posedge clk);
      global_mask_clear <= i;
      nonmaskable_mask_clear <= x;
      @(posedge clk);
      global_mask_clear <= 1'b0;
      nonmaskable_mask_clear <= 1'b0;
   endtask : clr
   // Lets the CPU end instructions until one take; an expected 0000 means none.
   // It returns after stacking has set the masks, so a following clear is not overridden.
   task automatic take(input logic [15:0] exp);
      logic got;
      got = 1'b0;
      @(posedge clk);
      run <= 1'b1;
      for (int i = 0; i < 20 && !got; i++) begin
         @(posedge clk);
         #1 got = (take_irq === 1'b1);
      end
      run <= 1'b0;
      chk(got ? vector : resolver_pkg::VEC_NONE, exp);
      repeat (2) @(posedge clk);
   endtask : take
   task automatic do_reset(input logic b, input logic a, input logic wd);
      @(posedge clk);
      rstn <= 1'b0;
      mode_pin_b <= b;
      mode_pin_a <= a;
      watchdog_disable <= wd;
      repeat (10) @(posedge clk);
      chk(vector, resolver_pkg::VEC_RESET);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : do_reset
   // ==========================================================
   // Scenarios
   task automatic t_modes;
      logic [7:0] hp[4] = '{8'hC6, 8'h76, 8'h06, 8'h26};
      logic [2:0] md[4] = '{3'h6, 3'h3, 3'h0, 3'h1};
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1], m[0], !m[0]);
         rreg(resolver_pkg::PRIORITY_MISC_ADDR, hp[m]);
         chk({13'h0, mode}, {13'h0, md[m]});
         chk({7'h0, global_mask, nonmaskable_mask, stop_disable, clock_monitor_enable,
            watchdog_enable, watchdog_rate, realtime_rate}, {7'h0, 4'hE, m[0], 4'h0});
         rreg(resolver_pkg::CTRL_ADDR, 8'h80);
         if (m == 1) begin
            wreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h26);
            #1 chk({13'h0, mode}, {13'h0, resolver_pkg::MODE_EXPANDED});
         end
      end
   endtask : t_modes
   task automatic t_nonmask;
      logic [15:0] nv[5] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6};
      wreg(resolver_pkg::CTRL_ADDR, 8'hC0);
      for (int i = 0; i < 5; i++) begin
         {por_req, clkmon_req, watchdog_req, illegal_op, software_trap} <= 5'h1F >> i;
         take(nv[i]);
      end
      illegal_op <= 1'b1;
      nonmaskable_pin_n <= 1'b0;
      take(16'hFFF8);
      clr(1'b0, 1'b1);
      take(16'hFFF4);
      repeat (2) @(posedge clk);
      #1 chk(nonmaskable_mask, 1'b1);
      take(16'hFFF8);
      {illegal_op, software_trap} <= 2'h0;
      nonmaskable_pin_n <= 1'b1;
   endtask : t_nonmask
   task automatic t_mask;
      int idx;
      wreg(16'h1042, 8'hFF);
      wreg(16'h1043, 8'h7F);
      irq_pin_n <= 1'b0;
      periph_req <= 15'h7FFE;
      for (int c = 0; c < 16; c++) begin
         idx = c < 5 ? c + 10 : (c < 7 ? 0 : c - 6);
         wreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'(c));
         rreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h20 | 8'(c));
         clr(1'b1, 1'b0);
         take(16'hFFF2 - 16'(2 * idx));
      end
      wreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h06);
      for (int k = 0; k < 15; k++) begin
         irq_pin_n <= (k != 0);
         periph_req <= 15'h7FFE & ~((15'h1 << k) - 15'h1);
         clr(1'b1, 1'b0);
         take(16'hFFF2 - 16'(2 * k));
      end
      wreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h00);
      periph_req <= 15'h7BFE;
      clr(1'b1, 1'b0);
      take(16'hFFF0);
      periph_req <= 15'h4400;
      wreg(16'h1043, 8'h7D);
      clr(1'b1, 1'b0);
      take(16'hFFD6);
      wreg(16'h1043, 8'h7F);
      take(resolver_pkg::VEC_NONE);
      periph_req <= 15'h0000;
      clr(1'b1, 1'b0);
      wreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h03);
      rreg(resolver_pkg::PRIORITY_MISC_ADDR, 8'h20);
   endtask : t_mask
   // ==========================================================
   // Sequence and watchdog on the run length
   initial begin
      do_reset(1'b1, 1'b0, 1'b0);
      t_modes();
      t_nonmask();
      t_mask();
      stop_test();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
endmodule : reset_interrupt_priority_resolver_test
`default_nettype wire

/* File: resolver_checker_assertions.sv */
// Assertions on the ports of the reset and interrupt priority resolver.
// Assumes one clock domain and the resolver package compiled first.
`timescale 1ns/1ps
`default_nettype none
module resolver_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic instr_done,
   input wire logic stacked,
   input wire logic take_irq,
   input wire logic fetching,
   input wire logic [15:0] vector,
   input wire logic global_mask,
   input wire logic nonmaskable_mask,
   input wire logic stop_disable,
   input wire logic clock_monitor_enable,
   input wire logic [1:0] watchdog_rate,
   input wire logic [1:0] realtime_rate,
   input wire logic [2:0] mode
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rst_masks;
      $rose(rstn) |-> global_mask && nonmaskable_mask && stop_disable && !clock_monitor_enable;
   endproperty
   a_rst_masks: assert property (p_rst_masks) else $error("masks wrong after reset");
   property p_rst_rates;
      $rose(rstn) |-> watchdog_rate == 2'h0 && realtime_rate == 2'h0;
   endproperty
   a_rst_rates: assert property (p_rst_rates) else $error("rates wrong after reset");
   property p_fetch;
      $rose(rstn) |-> fetching [*3];
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch too short");
   property p_take_cause;
      take_irq |-> $past(instr_done) && !$past(fetching);
   endproperty
   a_take_cause: assert property (p_take_cause) else $error("take without boundary");
   property p_stack_i;
      stacked |=> global_mask;
   endproperty
   a_stack_i: assert property (p_stack_i) else $error("mask not set on stacking");
   property p_nmi_x;
      take_irq && vector == resolver_pkg::VEC_NMI ##1 stacked |=> nonmaskable_mask;
   endproperty
   a_nmi_x: assert property (p_nmi_x) else $error("pin mask not set");
   property p_vec_hold;
      $changed(vector) |-> take_irq;
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector moved alone");
   property p_mode_ok;
      mode inside {3'h0, 3'h1, 3'h6, 3'h3};
   endproperty
   a_mode_ok: assert property (p_mode_ok) else $error("illegal mode");
endmodule : resolver_checker
bind reset_interrupt_priority_resolver resolver_checker chk (.clk, .rstn, .instr_done, .stacked,
   .take_irq, .fetching, .vector, .global_mask, .nonmaskable_mask, .stop_disable,
   .clock_monitor_enable, .watchdog_rate, .realtime_rate, .mode);
`default_nettype wire

/* File: resolver_pkg.sv */
// Constants shared by the reset and interrupt priority resolver.
// Assumes a single 200 MHz bus clock and an 8-bit register port.
package resolver_pkg;
   // ==========================================================
   // Register map
   localparam logic [15:0] PRIORITY_MISC_ADDR = 16'h103C;
   localparam logic [15:0] CTRL_ADDR = 16'h1040;
   localparam logic [15:0] STATUS_ADDR = 16'h1041;
   localparam logic [15:0] ENABLE_LO_ADDR = 16'h1042;
   localparam logic [15:0] ENABLE_HI_ADDR = 16'h1043;
   // ==========================================================
   // Field positions and reset values
   localparam int BOOT_BIT = 7;
   localparam int SPECIAL_BIT = 6;
   localparam int MODE_A_BIT = 5;
   localparam int IRV_BIT = 4;
   localparam logic [3:0] PSEL_RESET = 4'h6;
   localparam logic [3:0] PSEL_RESERVED = 4'h5;
   localparam logic [3:0] PSEL_IRQ = 4'h6;
   localparam logic [2:0] MODE_SINGLE = 3'h0;
   localparam logic [2:0] MODE_EXPANDED = 3'h1;
   localparam logic [2:0] MODE_BOOT = 3'h6;
   localparam logic [2:0] MODE_TEST = 3'h3;
   localparam int NUM_MASKABLE = 15;
   localparam int FETCH_CYCLES = 3;
   localparam logic [1:0] FETCH_LAST = 2'h2;
   localparam logic [1:0] FETCH_DONE = 2'h3;
   // ==========================================================
   // Vector addresses
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [15:0] VEC_ILLOP = 16'hFFF8;
   localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
   localparam logic [15:0] VEC_NMI = 16'hFFF4;
   localparam logic [15:0] VEC_NONE = 16'h0000;
endpackage : resolver_pkg
